/* core/pin_sync.sv */
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule // pin_sync
`default_nettype wire

/* core/transmitter_mode_and_serial_port.sv */
// Mode select, serial port and status pins of the transmitter front end
// Functional notes
// - All three carrier select pins low selects serial mode, else manual.
// - In manual mode the carrier select pins choose the carrier setting.
// - In serial mode the shared pin is data out with select low, status two otherwise.
// - In manual mode the shared pin is an input, low ASK and high FSK.
// - Status one shows a selected status in serial mode, lock detect in manual.
// - Serial data in is sampled on each rising serial clock with select low.
// - A new output bit follows the select fall and each falling serial clock.
// - Deep shutdown high in low-voltage mode disables reset circuit and pulls.
// - Select is active low in serial mode and picks deviation in manual mode.
// - In manual mode data in is power MSB and serial clock is power LSB.
`timescale 1ns/1ps
`default_nettype none
module transmitter_mode_and_serial_port
    import txfe_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Mode and serial pins
    input wire logic carrier_sel_bit0,
    input wire logic carrier_sel_bit1,
    input wire logic carrier_sel_bit2,
    input wire logic chip_select_or_deviation,
    input wire logic serial_clock_or_power_lsb,
    input wire logic serial_in_or_power_msb,
    input wire logic deep_shutdown_in,
    input wire logic low_voltage_mode,
    // Shared modulation select / status two pin
    input wire logic mod_select_or_status_two_in,
    output logic mod_select_or_status_two_out,
    output logic mod_select_or_status_two_oe,
    // Status pin one and internal status
    output logic status_out_one,
    input wire logic lock_detect,
    input wire logic [STAT_W-1:0] status_sources,
    // Settings to the transmitter core
    output logic serial_mode,
    output logic [2:0] carrier_sel,
    output logic fsk_select,
    output logic large_deviation,
    output logic [1:0] power_level,
    output logic [FRAME_BITS-1:0] config_word,
    output logic por_enable,
    output logic pull_enable
);
    // ----------------------------------------------------------------
    // Reset release and pin synchronisers
    // ----------------------------------------------------------------
    logic rst_meta_r, rst_n;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_r <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n <= rst_meta_r;
        end
    end

    logic [9:0] pins_s;
    pin_sync #(.WIDTH(10)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d({low_voltage_mode, deep_shutdown_in, mod_select_or_status_two_in,
            serial_in_or_power_msb, serial_clock_or_power_lsb,
            chip_select_or_deviation, carrier_sel_bit2, carrier_sel_bit1,
            carrier_sel_bit0, lock_detect}),
        .q(pins_s)
    );
    logic lock_s, cs_s, sck_s, sdi_s, mod_s, shdn_s, lv_s;
    logic [2:0] freq_s;
    assign lock_s = pins_s[0];
    assign freq_s = pins_s[3:1];
    assign cs_s = pins_s[4];
    assign sck_s = pins_s[5];
    assign sdi_s = pins_s[6];
    assign mod_s = pins_s[7];
    assign shdn_s = pins_s[8];
    assign lv_s = pins_s[9];

    // ----------------------------------------------------------------
    // Serial port and settings
    // ----------------------------------------------------------------
    // Pins cross two flops, so each host phase must span several clocks;
    // the 3 MHz host limit leaves ample margin at 250 MHz.
    port_state_t state_r, state_nxt;
    logic cs_q_r, cs_q_nxt, sck_q_r, sck_q_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [FRAME_BITS-1:0] rx_r, rx_nxt, tx_r, tx_nxt, cfg_r, cfg_nxt;
    logic sdo_r, sdo_nxt;
    logic smode_r, smode_nxt, pin_out_r, pin_out_nxt, pin_oe_r, pin_oe_nxt;
    logic st1_r, st1_nxt, fsk_r, fsk_nxt, dev_r, dev_nxt;
    logic [2:0] car_r, car_nxt;
    logic [1:0] pwr_r, pwr_nxt;
    logic por_r, por_nxt, pull_r, pull_nxt;
    logic cs_fall, cs_rise, sck_rise, sck_fall, smode, shdn_act;

    assign smode = (freq_s == SERIAL_MODE_CODE);
    assign shdn_act = shdn_s & lv_s;
    assign cs_fall = cs_q_r & ~cs_s;
    assign cs_rise = ~cs_q_r & cs_s;
    assign sck_rise = ~sck_q_r & sck_s;
    assign sck_fall = sck_q_r & ~sck_s;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        rx_nxt = rx_r;
        tx_nxt = tx_r;
        sdo_nxt = sdo_r;
        cfg_nxt = cfg_r;
        cs_q_nxt = cs_s;
        sck_q_nxt = sck_s;
        case (state_r)
            ST_IDLE: begin
                if (smode && cs_fall) begin
                    state_nxt = ST_SHIFT;
                    cnt_nxt = '0;
                    tx_nxt = cfg_r;
                    sdo_nxt = cfg_r[FRAME_BITS-1];
                end
            end
            ST_SHIFT: begin
                if (cs_rise || !smode) begin
                    state_nxt = ST_IDLE;
                    if (cs_rise && cnt_r == FRAME_CNT) begin
                        cfg_nxt = rx_r;
                    end
                end else if (sck_rise) begin
                    rx_nxt = {rx_r[FRAME_BITS-2:0], sdi_s};
                    if (cnt_r != CNT_SAT) begin
                        cnt_nxt = cnt_r + 5'h01;
                    end
                end else if (sck_fall) begin
                    tx_nxt = {tx_r[FRAME_BITS-2:0], 1'b0};
                    sdo_nxt = tx_r[FRAME_BITS-2];
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
        if (shdn_act) begin
            // Contents are lost in deep shutdown; host must rewrite
            state_nxt = ST_IDLE;
            cfg_nxt = CFG_RESET;
        end
        smode_nxt = smode;
        por_nxt = ~shdn_act;
        pull_nxt = ~shdn_act;
        if (smode) begin
            pin_oe_nxt = 1'b1;
            pin_out_nxt = cs_s ? status_sources[cfg_r[F_GPO2_SEL +: SEL_W]]
                               : sdo_r;
            st1_nxt = status_sources[cfg_r[F_STATUS_OUT_ONE_SEL +: SEL_W]];
            car_nxt = cfg_r[F_CARRIER +: 3];
            fsk_nxt = cfg_r[F_FSK];
            dev_nxt = cfg_r[F_DEV];
            pwr_nxt = cfg_r[F_PWR +: 2];
        end else begin
            pin_oe_nxt = 1'b0;
            pin_out_nxt = 1'b0;
            st1_nxt = lock_s;
            car_nxt = freq_s;
            fsk_nxt = mod_s;
            dev_nxt = cs_s;
            pwr_nxt = {sdi_s, sck_s};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            // Same level as the synchroniser in reset: no false select edge
            cs_q_r <= 1'b0;
            sck_q_r <= 1'b0;
            cnt_r <= '0;
            rx_r <= '0;
            tx_r <= '0;
            cfg_r <= CFG_RESET;
            sdo_r <= 1'b0;
            smode_r <= 1'b0;
            pin_out_r <= 1'b0;
            pin_oe_r <= 1'b0;
            st1_r <= 1'b0;
            car_r <= 3'h0;
            fsk_r <= 1'b0;
            dev_r <= 1'b0;
            pwr_r <= 2'h0;
            por_r <= 1'b1;
            pull_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            cs_q_r <= cs_q_nxt;
            sck_q_r <= sck_q_nxt;
            cnt_r <= cnt_nxt;
            rx_r <= rx_nxt;
            tx_r <= tx_nxt;
            cfg_r <= cfg_nxt;
            sdo_r <= sdo_nxt;
            smode_r <= smode_nxt;
            pin_out_r <= pin_out_nxt;
            pin_oe_r <= pin_oe_nxt;
            st1_r <= st1_nxt;
            car_r <= car_nxt;
            fsk_r <= fsk_nxt;
            dev_r <= dev_nxt;
            pwr_r <= pwr_nxt;
            por_r <= por_nxt;
            pull_r <= pull_nxt;
        end
    end

    assign serial_mode = smode_r;
    assign mod_select_or_status_two_out = pin_out_r;
    assign mod_select_or_status_two_oe = pin_oe_r;
    assign status_out_one = st1_r;
    assign carrier_sel = car_r;
    assign fsk_select = fsk_r;
    assign large_deviation = dev_r;
    assign power_level = pwr_r;
    assign config_word = cfg_r;
    assign por_enable = por_r;
    assign pull_enable = pull_r;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_frame_end;
        state_r == ST_SHIFT && cs_rise && !shdn_act;
    endsequence
    property p_mode_sel;
        @(posedge clk) disable iff (!rst_n)
        1'b1 |=> (serial_mode == ($past(freq_s) == SERIAL_MODE_CODE));
    endproperty
    a_mode_sel: assert property (p_mode_sel)
        else $error("mode does not follow carrier select pins");
    property p_manual_car;
        @(posedge clk) disable iff (!rst_n)
        !smode |=> carrier_sel == $past(freq_s);
    endproperty
    a_manual_car: assert property (p_manual_car)
        else $error("manual carrier select wrong");
    property p_sdo;
        @(posedge clk) disable iff (!rst_n)
        (smode && !cs_s) |=> mod_select_or_status_two_out == $past(sdo_r)
            && mod_select_or_status_two_oe;
    endproperty
    a_sdo: assert property (p_sdo)
        else $error("shared pin not data out with select low");
    property p_manual_in;
        @(posedge clk) disable iff (!rst_n)
        !smode |=> !mod_select_or_status_two_oe && fsk_select == $past(mod_s);
    endproperty
    a_manual_in: assert property (p_manual_in)
        else $error("shared pin not modulation input in manual mode");
    property p_lock;
        @(posedge clk) disable iff (!rst_n)
        !smode |=> status_out_one == $past(lock_s);
    endproperty
    a_lock: assert property (p_lock)
        else $error("status one not lock detect in manual mode");
    property p_sample;
        @(posedge clk) disable iff (!rst_n)
        (state_r == ST_SHIFT && smode && !cs_rise && sck_rise && !shdn_act)
            |=> rx_r[0] == $past(sdi_s);
    endproperty
    a_sample: assert property (p_sample)
        else $error("serial input not sampled on rising clock");
    property p_first_bit;
        @(posedge clk) disable iff (!rst_n)
        (state_r == ST_IDLE && smode && cs_fall && !shdn_act)
            |=> sdo_r == config_word[FRAME_BITS-1];
    endproperty
    a_first_bit: assert property (p_first_bit)
        else $error("first output bit not loaded at select fall");
    property p_shdn;
        @(posedge clk) disable iff (!rst_n)
        shdn_act |=> !por_enable && !pull_enable && config_word == CFG_RESET;
    endproperty
    a_shdn: assert property (p_shdn)
        else $error("deep shutdown not applied");
    property p_power;
        @(posedge clk) disable iff (!rst_n)
        !smode |=> power_level == {$past(sdi_s), $past(sck_s)}
            && large_deviation == $past(cs_s);
    endproperty
    a_power: assert property (p_power)
        else $error("manual power or deviation wrong");
    property p_short;
        @(posedge clk) disable iff (!rst_n)
        (s_frame_end and (cnt_r != FRAME_CNT)) |=> $stable(config_word);
    endproperty
    a_short: assert property (p_short)
        else $error("short frame changed configuration");
endmodule // transmitter_mode_and_serial_port
`default_nettype wire

/* core/txfe_pkg.sv */
// Shared constants for the transmitter mode and serial port front end
package txfe_pkg;
    // ----------------------------------------------------------------
    // Frame and configuration word
    // ----------------------------------------------------------------
    localparam int FRAME_BITS = 16;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] FRAME_CNT = 5'h10;
    localparam logic [CNT_W-1:0] CNT_SAT = 5'h11;
    localparam logic [FRAME_BITS-1:0] CFG_RESET = 16'h0000;
    // Field positions inside the configuration word
    localparam int F_STATUS_OUT_ONE_SEL = 0;
    localparam int F_GPO2_SEL = 3;
    localparam int F_FSK = 6;
    localparam int F_DEV = 7;
    localparam int F_PWR = 8;
    localparam int F_CARRIER = 10;
    localparam int SEL_W = 3;
    localparam int STAT_W = 8;
    localparam logic [2:0] SERIAL_MODE_CODE = 3'h0;
    // Serial clock limit the host must keep
    localparam int SCLK_MAX_KHZ = 3000;
    localparam int SYNC_STAGES = 2;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SHIFT = 2'b10
    } port_state_t;
endpackage

/* dv/spi_host_model.sv */
// Host controller model that masters the serial port
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    // Clock and returned data pin
    input wire logic clk,
    input wire logic sdo_pin,
    // Serial pins towards the device
    output logic cs_n,
    output logic sclk,
    output logic sdi
);
    // Half period of a 3 MHz serial clock, slow on purpose
    localparam int HALF = 42;
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        sdi = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Direct pin levels for manual mode
    task automatic pins(input logic c, input logic k, input logic d);
        tick(1);
        cs_n = c;
        sclk = k;
        sdi = d;
    endtask
    // Shifts nbits of w MSB first and returns what came back
    task automatic frame(input logic [15:0] w, input int nbits,
                         output logic [15:0] rd);
        rd = 16'h0000;
        tick(1);
        sclk = 1'b0;
        tick(HALF);
        cs_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            sdi = (i < 16) ? w[15-i] : 1'b0;
            tick(HALF);
            sclk = 1'b1;
            rd = {rd[14:0], sdo_pin};
            tick(HALF);
            sclk = 1'b0;
        end
        tick(HALF);
        cs_n = 1'b1;
        // A released data line must not look like a held bit
        sdi = ~sdi;
        tick(3 * HALF);
    endtask
endmodule // spi_host_model
`default_nettype wire

/* dv/testbench.sv */
// Self-checking bench for the transmitter mode and serial port front end
`timescale 1ns/1ps
`default_nettype none
module testbench import txfe_pkg::*;;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [2:0] freq = 3'h0;
    logic shdn = 1'b0;
    logic lv = 1'b1;
    logic mod_drv = 1'b0;
    logic lock = 1'b0;
    logic [STAT_W-1:0] src = 8'h48;
    logic cs_n, sclk, sdi, mod_out, mod_oe, mod_pin, st1, smode;
    logic fsk, dev, por, pull;
    logic [2:0] csel;
    logic [1:0] pwr;
    logic [FRAME_BITS-1:0] cfg;
    logic [15:0] rd;
    int bad_count = 0;
    int comparisons = 0;
    always #2 clk = ~clk;
    // Level the bench drives (mod_drv) when the device does not drive the shared pin
    assign mod_pin = mod_oe ? mod_out : mod_drv;
    spi_host_model host (.clk(clk), .sdo_pin(mod_pin), .cs_n(cs_n),
        .sclk(sclk), .sdi(sdi));
    transmitter_mode_and_serial_port dut (.clk(clk), .reset_n(reset_n),
        .carrier_sel_bit0(freq[0]), .carrier_sel_bit1(freq[1]),
        .carrier_sel_bit2(freq[2]), .chip_select_or_deviation(cs_n),
        .serial_clock_or_power_lsb(sclk), .serial_in_or_power_msb(sdi),
        .deep_shutdown_in(shdn), .low_voltage_mode(lv),
        .mod_select_or_status_two_in(mod_pin),
        .mod_select_or_status_two_out(mod_out),
        .mod_select_or_status_two_oe(mod_oe), .status_out_one(st1),
        .lock_detect(lock), .status_sources(src), .serial_mode(smode),
        .carrier_sel(csel), .fsk_select(fsk), .large_deviation(dev),
        .power_level(pwr), .config_word(cfg), .por_enable(por),
        .pull_enable(pull));
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time,
                     seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Bounded wait for a committed word; running out ends the run
    task automatic wait_cfg(input logic [15:0] exp);
        for (int i = 0; i < 30 && cfg !== exp; i++) tick(1);
        check(cfg, exp);
        if (cfg !== exp) final_report();
        tick(3);
    endtask
    task automatic serial_settings(input logic [15:0] c);
        check(smode, 1'b1);
        check(mod_oe, 1'b1);
        check(csel, c[12:10]);
        check({fsk, dev, pwr}, {c[6], c[7], c[9:8]});
        check(st1, src[c[2:0]]);
        check(mod_pin, src[c[5:3]]);
    endtask
    task automatic test_frames();
        host.frame(16'h169E, 16, rd);
        check(rd, 16'h0000);
        wait_cfg(16'h169E);
        serial_settings(16'h169E);
        host.frame(16'h0961, 16, rd);
        check(rd, 16'h169E);
        wait_cfg(16'h0961);
        serial_settings(16'h0961);
        $display("test frames done");
    endtask
    task automatic test_short();
        host.frame(16'hFFFF, 8, rd);
        check(rd, 16'h0009);
        tick(20);
        check(cfg, 16'h0961);
        // One bit too many is refused as well
        host.frame(16'hFFFF, 17, rd);
        check(rd, 16'h12C2);
        tick(20);
        check(cfg, 16'h0961);
        // Leaving serial mode mid frame drops the frame
        fork
            host.frame(16'hFFFF, 16, rd);
            begin
                tick(400);
                freq = 3'h1;
                tick(200);
                freq = 3'h0;
            end
        join
        tick(20);
        check(cfg, 16'h0961);
        $display("test short frame done");
    endtask
    task automatic test_manual();
        for (int i = 1; i < 8; i++) begin
            logic [2:0] v;
            v = i[2:0];
            host.pins(v[1], v[0], v[2]);
            mod_drv = ~v[0];
            lock = v[0] ^ v[1];
            freq = v;
            tick(10);
            check(smode, 1'b0);
            check(csel, v);
            check({mod_oe, fsk}, {1'b0, ~v[0]});
            check(dev, v[1]);
            check(pwr, {v[2], v[0]});
            check(st1, lock);
        end
        host.pins(1'b1, 1'b0, 1'b0);
        freq = 3'h0;
        tick(10);
        check({smode, mod_oe}, 2'b11);
        $display("test manual mode done");
    endtask
    task automatic test_shutdown();
        lv = 1'b0;
        shdn = 1'b1;
        tick(10);
        check({por, pull}, 2'b11);
        check(cfg, 16'h0961);
        lv = 1'b1;
        tick(10);
        check({por, pull}, 2'b00);
        check(cfg, 16'h0000);
        shdn = 1'b0;
        tick(10);
        check({por, pull}, 2'b11);
        // Contents are lost, so the host writes them again
        host.frame(16'h169E, 16, rd);
        check(rd, 16'h0000);
        wait_cfg(16'h169E);
        serial_settings(16'h169E);
        $display("test shutdown done");
    endtask
    task automatic test_reset();
        tick(2);
        reset_n = 1'b1;
        tick(12);
        check({por, pull}, 2'b11);
        check(cfg, 16'h0000);
        check({smode, mod_oe}, 2'b11);
        $display("test reset done");
    endtask
    initial begin
        test_reset();
        test_frames();
        test_short();
        test_manual();
        test_shutdown();
        final_report();
    end
endmodule // testbench
`default_nettype wire
